// >>> rtl/flash_host_pkg.sv
package flash_host_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int BYTE_ADDR_W = 21;
    localparam int CLK_MHZ = 25;
    localparam int ACCESS_NS = 70;
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_PULSE_NS = 70;
    localparam int WRITE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_NS = 500;
    localparam int RESET_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h002aa;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
    localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT2 = 16'h0000;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_PROGRAM = 4'h1,
        OP_SECTOR_ERASE = 4'h2,
        OP_CHIP_ERASE = 4'h3,
        OP_SUSPEND = 4'h4,
        OP_RESUME = 4'h5,
        OP_BYPASS_ENTER = 4'h6,
        OP_BYPASS_EXIT = 4'h7,
        OP_RESET_CMD = 4'h8,
        OP_HW_RESET = 4'h9,
        OP_WRITE_RAW = 4'ha
    } op_e;

    typedef struct packed {
        op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_s;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic reset_n;
        logic byte_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic dout_en;
    } pins_s;
endpackage

// >>> rtl/flash_bus_cycle.sv
`timescale 1ns/100ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] din_sync,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output pins_s pins
);
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_PULSE = 2'b01,
        C_RECOVER = 2'b11
    } cyc_e;

    typedef struct packed {
        cyc_e st;
        logic [CNT_W-1:0] cnt;
        logic wr;
        logic done;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
    } st_s;

    st_s s;
    st_s next_s;

    // reads wait two extra cycles for the pin synchroniser on the data bus
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(ACCESS_CYC + 2);
    localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'(WRITE_CYC);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            C_IDLE: begin
                if (start) begin
                    next_s.st = C_PULSE;
                    next_s.wr = is_write;
                    next_s.addr = addr;
                    next_s.wdata = wdata;
                    next_s.cnt = is_write ? WR_WAIT : RD_WAIT;
                end
            end
            C_PULSE: begin
                if (s.cnt == '0) begin
                    if (!s.wr) begin
                        next_s.rdata = din_sync;
                    end
                    next_s.st = C_RECOVER;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            C_RECOVER: begin
                next_s.st = C_IDLE;
                next_s.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '{st: C_IDLE, cnt: '0, wr: 1'b0, done: 1'b0, addr: '0, wdata: '0, rdata: '0};
        end else begin
            s <= next_s;
        end
    end

    assign busy = (s.st != C_IDLE);
    assign done = s.done;
    assign rdata = s.rdata;
    always_comb begin
        pins = '0;
        // chip select spans the recovery cycle so the strobes rise first and the latch edge is clean
        pins.cs_n = (s.st == C_IDLE);
        pins.we_n = !(s.st == C_PULSE && s.wr);
        pins.oe_n = !(s.st == C_PULSE && !s.wr);
        pins.reset_n = 1'b1;
        pins.byte_n = 1'b1;
        pins.addr = s.addr;
        pins.dout = s.wdata;
        // host drives data only during write cycles, never with oe low
        pins.dout_en = s.wr && (s.st != C_IDLE);
    end

    strobe_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(!pins.we_n && !pins.oe_n)) else $error("write and output strobes both low");
    write_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.we_n) |-> !pins.we_n [*2]) else $error("write strobe too short");
endmodule

// >>> rtl/flash_host.sv
`timescale 1ns/100ps
module flash_host
    import flash_host_pkg::*;
#(
    parameter int TIMEOUT_CYC = 100000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input req_s req,
    input wire logic byte_mode,
    input wire logic standby,
    output logic req_ready,
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_data,
    output logic resp_error,
    output logic bypass_active,
    output logic erase_suspended,
    output logic cs_n,
    output logic we_n,
    output logic oe_n,
    output logic reset_n,
    output logic byte_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [DATA_W-1:0] data_bus_in,
    input wire logic operation_done_pin
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SEQ = 3'b001,
        H_WAIT_CYC = 3'b011,
        H_POLL = 3'b010,
        H_RESET = 3'b110,
        H_DONE = 3'b111
    } host_e;

    localparam int SEQ_MAX = 6;

    typedef struct packed {
        host_e st;
        op_e op;
        logic [2:0] step;
        logic [2:0] nsteps;
        logic bypass;
        logic susp;
        logic poll_pend;
        logic [31:0] tmo;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] result;
        logic err;
        logic first_rd;
        logic toggle_prev;
    } st_s;

    st_s s;
    st_s next_s;
    logic [DATA_W-1:0] din_meta;
    logic [DATA_W-1:0] din_sync;
    logic rdy_meta;
    logic rdy_sync;
    logic cyc_start;
    logic cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;
    logic cyc_busy;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    pins_s cyc_pins;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            din_meta <= '0;
            din_sync <= '0;
            rdy_meta <= 1'b1;
            rdy_sync <= 1'b1;
        end else begin
            din_meta <= data_bus_in;
            din_sync <= din_meta;
            rdy_meta <= operation_done_pin;
            rdy_sync <= rdy_meta;
        end
    end

    flash_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .din_sync(din_sync),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .pins(cyc_pins)
    );

    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_e op, input logic [2:0] i,
                                                         input logic byp, input logic [ADDR_W-1:0] a,
                                                         input logic [DATA_W-1:0] d);
        logic [ADDR_W+DATA_W-1:0] w;
        w = {UNLOCK_A1, CMD_RESET};
        unique case (op)
            OP_PROGRAM: begin
                if (byp) w = (i == 3'd0) ? {a, CMD_PROGRAM} : {a, d};
                else if (i == 3'd0) w = {UNLOCK_A1, UNLOCK_D1};
                else if (i == 3'd1) w = {UNLOCK_A2, UNLOCK_D2};
                else if (i == 3'd2) w = {UNLOCK_A1, CMD_PROGRAM};
                else w = {a, d};
            end
            OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
                if (i == 3'd0 || i == 3'd3) w = {UNLOCK_A1, UNLOCK_D1};
                else if (i == 3'd1 || i == 3'd4) w = {UNLOCK_A2, UNLOCK_D2};
                else if (i == 3'd2) w = {UNLOCK_A1, CMD_ERASE_SETUP};
                else if (op == OP_CHIP_ERASE) w = {UNLOCK_A1, CMD_CHIP_ERASE};
                else w = {a, CMD_SECTOR_ERASE};
            end
            OP_BYPASS_ENTER: begin
                if (i == 3'd0) w = {UNLOCK_A1, UNLOCK_D1};
                else if (i == 3'd1) w = {UNLOCK_A2, UNLOCK_D2};
                else w = {UNLOCK_A1, CMD_BYPASS};
            end
            OP_BYPASS_EXIT: w = (i == 3'd0) ? {a, CMD_BYPASS_EXIT1} : {a, CMD_BYPASS_EXIT2};
            OP_SUSPEND: w = {a, CMD_SUSPEND};
            OP_RESUME: w = {a, CMD_RESUME};
            OP_WRITE_RAW: w = {a, d};
            default: w = {UNLOCK_A1, CMD_RESET};
        endcase
        return w;
    endfunction

    function automatic logic [2:0] seq_len(input op_e op, input logic byp);
        logic [2:0] n;
        unique case (op)
            OP_PROGRAM: n = byp ? 3'd2 : 3'd4;
            OP_SECTOR_ERASE, OP_CHIP_ERASE: n = 3'(SEQ_MAX);
            OP_BYPASS_ENTER: n = 3'd3;
            OP_BYPASS_EXIT: n = 3'd2;
            default: n = 3'd1;
        endcase
        return n;
    endfunction

    logic [ADDR_W+DATA_W-1:0] cur_word;
    assign cur_word = seq_word(s.op, s.step, s.bypass, s.addr, s.data);

    always_comb begin
        next_s = s;
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_addr = cur_word[ADDR_W+DATA_W-1:DATA_W];
        cyc_data = cur_word[DATA_W-1:0];
        unique case (s.st)
            H_IDLE: begin
                if (req_valid && !standby) begin
                    next_s.op = req.op;
                    next_s.addr = req.addr;
                    next_s.data = req.data;
                    next_s.step = '0;
                    next_s.err = 1'b0;
                    next_s.nsteps = seq_len(req.op, s.bypass);
                    if (req.op == OP_HW_RESET) begin
                        next_s.tmo = 32'(RESET_CYC);
                        next_s.st = H_RESET;
                    end else begin
                        next_s.st = H_SEQ;
                    end
                end
            end
            H_SEQ: begin
                if (!cyc_busy) begin
                    cyc_start = 1'b1;
                    cyc_write = (s.op != OP_READ);
                    if (s.op == OP_READ) cyc_addr = s.addr;
                    next_s.st = H_WAIT_CYC;
                end
            end
            H_WAIT_CYC: begin
                if (cyc_done) begin
                    if (s.poll_pend) begin
                        // toggle bit stops toggling when the operation ends
                        if (!s.first_rd && cyc_rdata[TOGGLE_BIT] == s.toggle_prev) begin
                            next_s.poll_pend = 1'b0;
                            next_s.st = H_DONE;
                        end else if (s.tmo == '0) begin
                            next_s.err = 1'b1;
                            next_s.poll_pend = 1'b0;
                            next_s.st = H_DONE;
                        end else begin
                            next_s.st = H_POLL;
                        end
                        next_s.first_rd = 1'b0;
                        next_s.toggle_prev = cyc_rdata[TOGGLE_BIT];
                        next_s.result = cyc_rdata;
                    end else if (s.op == OP_READ) begin
                        next_s.result = cyc_rdata;
                        next_s.st = H_DONE;
                    end else if (s.step + 1'b1 < s.nsteps) begin
                        next_s.step = s.step + 1'b1;
                        next_s.st = H_SEQ;
                    end else begin
                        if (s.op == OP_BYPASS_ENTER) next_s.bypass = 1'b1;
                        if (s.op == OP_BYPASS_EXIT || s.op == OP_RESET_CMD) next_s.bypass = 1'b0;
                        // suspend state tracked for the user side
                        if (s.op == OP_SUSPEND) next_s.susp = 1'b1;
                        if (s.op == OP_RESUME || s.op == OP_RESET_CMD) next_s.susp = 1'b0;
                        // device runs its own algorithm; host just waits
                        if (s.op == OP_PROGRAM || s.op == OP_SECTOR_ERASE || s.op == OP_CHIP_ERASE ||
                            s.op == OP_RESUME) begin
                            next_s.poll_pend = 1'b1;
                            next_s.first_rd = 1'b1;
                            next_s.tmo = 32'(TIMEOUT_CYC);
                            next_s.st = H_POLL;
                        end else begin
                            next_s.st = H_DONE;
                        end
                    end
                end
            end
            H_POLL: begin
                if (s.tmo != '0) next_s.tmo = s.tmo - 1'b1;
                // ready pin high means finished except after a resume; toggle reads cover a floating pin
                if (rdy_sync && !s.first_rd && s.op != OP_RESUME) begin
                    next_s.poll_pend = 1'b0;
                    next_s.st = H_DONE;
                end else if (!cyc_busy) begin
                    cyc_start = 1'b1;
                    cyc_write = 1'b0;
                    cyc_addr = s.addr;
                    next_s.st = H_WAIT_CYC;
                end
            end
            H_RESET: begin
                // hold the reset pin low for the minimum pulse
                if (s.tmo == '0) begin
                    next_s.bypass = 1'b0;
                    next_s.susp = 1'b0;
                    next_s.st = H_DONE;
                end else begin
                    next_s.tmo = s.tmo - 1'b1;
                end
            end
            H_DONE: next_s.st = H_IDLE;
            default: next_s.st = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '{st: H_IDLE, op: OP_READ, step: '0, nsteps: '0, bypass: 1'b0, susp: 1'b0,
                   poll_pend: 1'b0, tmo: '0, addr: '0, data: '0, result: '0, err: 1'b0,
                   first_rd: 1'b0, toggle_prev: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign req_ready = (s.st == H_IDLE) && !standby;
    assign resp_valid = (s.st == H_DONE);
    assign resp_data = s.result;
    assign resp_error = s.err;
    assign bypass_active = s.bypass;
    assign erase_suspended = s.susp;
    assign cs_n = cyc_pins.cs_n;
    assign we_n = cyc_pins.we_n;
    assign oe_n = cyc_pins.oe_n;
    assign reset_n = (s.st != H_RESET);
    // byte pin low selects x8 lanes
    assign byte_n = !byte_mode;
    assign addr = cyc_pins.addr;
    assign data_bus_out = byte_mode ? {8'h00, cyc_pins.dout[BYTE_W-1:0]} : cyc_pins.dout;
    assign data_bus_oe = cyc_pins.dout_en;

    reset_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(reset_n) |-> !reset_n [*8]) else $error("reset pulse too short");
    bypass_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == H_IDLE && req_valid && !standby && req.op == OP_PROGRAM && s.bypass)
        |=> s.nsteps == 3'd2) else $error("bypass program not two writes");
    prog_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == H_IDLE && req_valid && !standby && req.op == OP_PROGRAM && !s.bypass)
        |=> s.nsteps == 3'd4) else $error("program not four writes");
    standby_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        (standby && s.st == H_IDLE) |=> cs_n) else $error("chip selected in standby");
    poll_done_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == H_POLL && rdy_sync && !s.first_rd && s.op != OP_RESUME) |=> resp_valid)
        else $error("ready pin not honoured");
    suspend_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        (resp_valid && s.op == OP_SUSPEND && !s.err) |-> erase_suspended)
        else $error("suspend not recorded");
    drive_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
        data_bus_oe |-> oe_n) else $error("host drives bus while device output enabled");
    reset_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(reset_n) |-> !bypass_active && !erase_suspended) else $error("reset left mode set");
endmodule

// >>> verification/flash_device_model.sv
`timescale 1ns/100ps
module flash_device_model #(
    parameter int PROG_NS = 1000,
    parameter int ERASE_NS = 4000,
    parameter int PROT_SEC = 12,
    parameter bit WP_LOW = 1'b0
) (
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_n,
    input wire logic byte_n,
    input wire logic [19:0] addr,
    input wire logic [15:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [15:0] data_bus_in,
    output logic operation_done_pin
);
    logic [15:0] mem [int];
    logic [15:0] q = 16'h0000;
    logic [15:0] w;
    logic [7:0] tgt = 8'h00;
    logic tog = 1'b0;
    bit busy, susp, byp;
    bit vcc_low;
    int st, left;

    function automatic int sec(input logic [19:0] a);
        return (a[19:15] == 5'h00) ? int'(a[14:12]) : 7 + int'(a[19:15]);
    endfunction

    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
    endfunction

    task automatic go(input int ns, input logic [7:0] t);
        busy = 1;
        left = ns;
        tgt = t;
    endtask

    // decode, any stray write drops the sequence except in cycle six, where any data but 0010h erases the addressed sector
    // entry codes other than the bypass entry (0020h) are never sent by this host, so they fall through as stray writes
    task automatic cmd(input logic [19:0] a, input logic [15:0] d);
        if (busy && !susp) begin
            // only an erase, or a program whose data low byte is FFh, may be held
            susp = (d == 16'h00b0 && tgt == 8'hff);
        end else if (susp && st == 0 && d == 16'h0030) begin
            susp = 0;
        end else if (st == 0 && byp) begin
            st = (d == 16'h00a0) ? 3 : (d == 16'h0090) ? 9 : 0;
        end else if (st == 9) begin
            byp = (d != 16'h0000);
            st = 0;
        end else if (st == 0 || st == 4) begin
            st = (a[10:0] == 11'h555 && d == 16'h00aa) ? st + 1 : 0;
        end else if (st == 1 || st == 5) begin
            st = (a[10:0] == 11'h2aa && d == 16'h0055) ? st + 1 : 0;
        end else if (st == 2) begin
            byp = (d == 16'h0020);
            st = (d == 16'h00a0) ? 3 : (d == 16'h0080) ? 4 : 0;
        end else if (st == 3) begin
            st = 0;
            // program unless protected or the two lowest boot sectors are write protected
            if (sec(a) != PROT_SEC && !(WP_LOW && sec(a) < 2)) begin
                mem[int'(a)] = rd(a) & d;
                go(PROG_NS, d[7:0]);
            end
        end else begin
            st = 0;
            foreach (mem[k]) if (d == 16'h0010 || sec(20'(k)) == sec(a)) mem[k] = 16'hffff;
            go(ERASE_NS, 8'hff);
        end
    endtask

    // writes dropped while the supply detector trips
    always @(posedge we_n) if (!cs_n && reset_n && !vcc_low) cmd(addr, data_bus_out);

    always #20 begin
        if (busy && !susp) left = left - 20;
        if (left <= 0) busy = 0;
    end

    always @(negedge reset_n) begin
        busy = 0;
        susp = 0;
        byp = 0;
        st = 0;
    end

    // poll and toggle bits while busy
    // a read returns array data whatever the sleep or standby state
    always @(negedge oe_n) begin
        // address moves in the same step as the strobe, so let it settle
        #1;
        w = rd(addr);
        if (busy && !susp) begin
            tog = ~tog;
            q = {8'h00, ~tgt[7], tog, 6'h00};
        end else begin
            q = byte_n ? w : {~q[15:8], w[7:0]};
        end
    end
    // released bus must not keep the last value
    always @(posedge oe_n) q = ~q;
    assign operation_done_pin = !(busy && !susp);
    assign data_bus_in = data_bus_oe ? data_bus_out : q;
endmodule

// >>> verification/tb_flash_host.sv
`timescale 1ns/100ps
module tb_flash_host
    import flash_host_pkg::*;
;
    localparam int PROT = 12;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    req_s req = '0;
    logic byte_mode = 1'b0;
    logic standby = 1'b0;
    logic req_ready, resp_valid, resp_error, bypass_active, erase_suspended;
    logic cs_n, we_n, oe_n, reset_n, byte_n, data_bus_oe, operation_done_pin;
    logic [ADDR_W-1:0] addr, a;
    logic [DATA_W-1:0] resp_data, data_bus_out, data_bus_in, d;
    logic [DATA_W-1:0] shadow [int];
    logic [15:0] n_wr = 16'h0000;
    logic [15:0] n_poll = 16'h0000;
    logic [15:0] n_rst = 16'h0000;
    int num_errors = 0;
    int check_count = 0;
    int seed = 32'hd609;

    initial forever #20 ref_clk = ~ref_clk;
    always @(negedge we_n) n_wr++;
    always @(negedge oe_n) if (!operation_done_pin) n_poll++;
    always @(posedge ref_clk) if (!reset_n) n_rst++;

    flash_host #(.TIMEOUT_CYC(200)) uut (.ref_clk, .rst, .req_valid, .req, .byte_mode, .standby, .req_ready,
        .resp_valid, .resp_data, .resp_error, .bypass_active, .erase_suspended, .cs_n, .we_n, .oe_n, .reset_n,
        .byte_n, .addr, .data_bus_out, .data_bus_oe, .data_bus_in, .operation_done_pin);
    flash_device_model dev (.cs_n, .we_n, .oe_n, .reset_n, .byte_n, .addr, .data_bus_out, .data_bus_oe,
        .data_bus_in, .operation_done_pin);

    function automatic int sec(input logic [19:0] x);
        return (x[19:15] == 5'h00) ? int'(x[14:12]) : 7 + int'(x[19:15]);
    endfunction
    function automatic logic [15:0] exp_rd(input logic [19:0] x);
        return shadow.exists(int'(x)) ? shadow[int'(x)] : 16'hffff;
    endfunction

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // request held until taken, answer awaited under a bound
    task automatic run(input op_e op, input logic [19:0] x, input logic [15:0] y);
        int n;
        n = 0;
        tick();
        req = '{op, x, y};
        req_valid = 1'b1;
        while (!req_ready && n < 100) begin
            tick();
            n++;
        end
        tick();
        req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 1000) begin
            tick();
            n++;
        end
        check("response", {resp_error, resp_valid, 14'h0000}, 16'h4000);
        if (resp_valid !== 1'b1) finish_test();
    endtask
    task automatic prog(input logic [19:0] x, input logic [15:0] y);
        run(OP_PROGRAM, x, y);
        if (sec(x) != PROT) shadow[int'(x)] = exp_rd(x) & y;
    endtask
    task automatic verify(input logic [19:0] x);
        run(OP_READ, x, 16'h0000);
        check("read data", resp_data, exp_rd(x));
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        tick();
        check("idle pins", {11'h000, cs_n, we_n, oe_n, reset_n, data_bus_oe}, 16'h001e);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 20'hfffff : (i == 1) ? 20'h00000 : 20'($random(seed));
            if (sec(a) == PROT) a[19] = 1'b1;
            d = 16'($random(seed));
            n_wr = 16'h0000;
            n_poll = 16'h0000;
            prog(a, d);
            check("program writes", n_wr, 16'h0004);
            check("polled busy", {15'h0000, n_poll > 0}, 16'h0001);
            verify(a);
        end
        prog(20'h00fff, 16'h1234);
        prog(20'h01000, 16'h5678);
        run(OP_SECTOR_ERASE, 20'h01000, 16'h0000);
        foreach (shadow[k]) if (sec(20'(k)) == sec(20'h01000)) shadow[k] = 16'hffff;
        verify(20'h01000);
        verify(20'h00fff);
        run(OP_BYPASS_ENTER, 20'h00000, 16'h0000);
        check("bypass on", {15'h0000, bypass_active}, 16'h0001);
        n_wr = 16'h0000;
        prog(20'h40010, 16'h0f0f);
        check("bypass writes", n_wr, 16'h0002);
        run(OP_BYPASS_EXIT, 20'h00000, 16'h0000);
        check("bypass off", {15'h0000, bypass_active}, 16'h0000);
        verify(20'h40010);
        run(OP_WRITE_RAW, UNLOCK_A1, UNLOCK_D1);
        run(OP_WRITE_RAW, 20'h00123, 16'h0077);
        verify(20'h00fff);
        prog(20'h28004, 16'h0000);
        verify(20'h28004);
        run(OP_SUSPEND, 20'h00000, 16'h0000);
        check("suspended", {15'h0000, erase_suspended}, 16'h0001);
        run(OP_RESUME, 20'h00000, 16'h0000);
        check("resumed", {15'h0000, erase_suspended}, 16'h0000);
        run(OP_RESET_CMD, 20'h00000, 16'h0000);
        run(OP_HW_RESET, 20'h00000, 16'h0000);
        check("reset pulse", {15'h0000, n_rst >= 16'(RESET_CYC)}, 16'h0001);
        verify(20'h00fff);
        byte_mode = 1'b1;
        run(OP_READ, 20'h00fff, 16'h0000);
        check("byte pin", {15'h0000, byte_n}, 16'h0000);
        check("byte lane", {8'h00, resp_data[7:0]}, exp_rd(20'h00fff) & 16'h00ff);
        byte_mode = 1'b0;
        run(OP_CHIP_ERASE, 20'h00000, 16'h0000);
        shadow.delete();
        verify(20'h40010);
        standby = 1'b1;
        req_valid = 1'b1;
        repeat (10) tick();
        check("standby ready", {15'h0000, req_ready}, 16'h0000);
        check("standby select", {15'h0000, cs_n}, 16'h0001);
        req_valid = 1'b0;
        standby = 1'b0;
        finish_test();
    end
endmodule
